/* hw/iopc_top.v */
// Eight-bit port with pull-ups, output latch and interrupt-on-change
`timescale 1ns/1ps
`default_nettype none
`include "iopc_consts.vh"

// Contract
// - Pull-up on where enabled and input
// - Flag register ignores writes
// - Flag bit shows pin interrupt condition
// - Later pins still flag, capture kept
// - Capture port levels on activating event
// - Capture held until capture/port read
// - Only reads clear interrupt, writes don't
// - Interrupt pin active while pending
// - No new interrupt while pending
// - Output pins never raise interrupts
// - Mode picks reference or previous compare
// - Previous mode: change interrupts, reference follows
// - Reference mode condition lasts while mismatched
// - Port read gives pins, write hits latch
// - Latch read gives latch contents
// - Interrupt pin push-pull/open-drain, selectable level
// - Open-drain overrides polarity; polarity one high
// - Enable bit one arms pin
// - Mode one compares against reference
// - Pin opposite reference bit is condition
module iopc_top #(
  parameter WIDTH = 8,
  parameter SYNC_STAGES = `IOPC_SYNC_STAGES
) (
  // Clock, reset and enable
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  // Register port from the serial engine
  input wire [7:0] I_REG_ADDR,
  input wire I_REG_WR,
  input wire [WIDTH-1:0] I_REG_WDATA,
  input wire I_REG_RD,
  output reg [WIDTH-1:0] O_REG_RDATA,
  output reg O_REG_RVALID,
  // Port pins
  input wire [WIDTH-1:0] I_PIN_LEVEL,
  input wire [WIDTH-1:0] I_PIN_IS_INPUT,
  output reg [WIDTH-1:0] O_LATCH,
  output reg [WIDTH-1:0] O_PULLUP_EN,
  // Interrupt pin
  output reg O_INT_OUT,
  output reg O_INT_OE
);

  // ==========================================================
  // Registers
  reg [WIDTH-1:0] chg_irq_enable;
  reg [WIDTH-1:0] reference_compare_value;
  reg [WIDTH-1:0] compare_mode_select;
  reg [7:0] expander_config;
  reg [WIDTH-1:0] pullup_enable;
  reg [WIDTH-1:0] interrupt_flags;
  reg [WIDTH-1:0] captured_port_value;
  reg [WIDTH-1:0] previous_level;
  reg irq_state;

  // ==========================================================
  // Interrupt states and pin drive modes
  localparam ST_IDLE = 1'b0;
  localparam ST_HELD = 1'b1;
  localparam PIN_PUSH_LOW = 2'b00;
  localparam PIN_PUSH_HIGH = 2'b01;

  // ==========================================================
  // Next values and decode
  wire [WIDTH-1:0] port_bits;
  wire [WIDTH-1:0] pin_cond;
  wire [WIDTH-1:0] next_flags;
  wire any_cond;
  wire irq_pending;
  wire next_pending;
  wire rd_clear;
  wire new_event;
  wire open_drain_select;
  wire irq_polarity;
  reg wr_chg_en;
  reg wr_ref_val;
  reg wr_mode_sel;
  reg wr_config;
  reg wr_pullup;
  reg wr_latch;
  reg next_state;
  reg [WIDTH-1:0] next_rdata;
  reg next_int_out;
  reg next_int_oe;

  // ==========================================================
  // Pin synchroniser
  iopc_sync #(
    .WIDTH(WIDTH),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(I_CLK),
    .rst_n(I_RST_N),
    .ce(I_CE),
    .d(I_PIN_LEVEL),
    .q(port_bits)
  );

  // ==========================================================
  // Write decode; flags and capture have no write strobe
  always @* begin
    wr_chg_en = 1'b0;
    wr_ref_val = 1'b0;
    wr_mode_sel = 1'b0;
    wr_config = 1'b0;
    wr_pullup = 1'b0;
    wr_latch = 1'b0;
    case (I_REG_ADDR)
      `IOPC_ADDR_CHG_EN: begin
        wr_chg_en = I_REG_WR;
      end
      `IOPC_ADDR_REF_VAL: begin
        wr_ref_val = I_REG_WR;
      end
      `IOPC_ADDR_MODE_SEL: begin
        wr_mode_sel = I_REG_WR;
      end
      `IOPC_ADDR_CONFIG: begin
        wr_config = I_REG_WR;
      end
      `IOPC_ADDR_PULLUP: begin
        wr_pullup = I_REG_WR;
      end
      // Port writes land in the latch
      `IOPC_ADDR_PORT, `IOPC_ADDR_LATCH: begin
        wr_latch = I_REG_WR;
      end
      default: begin
        wr_latch = 1'b0;
      end
    endcase
  end

  // Only reads of capture or port clear; writes have no effect here
  assign rd_clear = I_REG_RD && ((I_REG_ADDR == `IOPC_ADDR_CAPTURE) ||
                                 (I_REG_ADDR == `IOPC_ADDR_PORT));

  assign open_drain_select = expander_config[`IOPC_CFG_OD_BIT];
  assign irq_polarity = expander_config[`IOPC_CFG_POL_BIT];

  // ==========================================================
  // Per-pin interrupt condition
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_cond
      wire armed;
      wire vs_ref;
      wire vs_prev;
      // Armed only for enabled input pins
      assign armed = chg_irq_enable[i] && I_PIN_IS_INPUT[i];
      // Mismatch with reference persists as long as it lasts
      assign vs_ref = port_bits[i] ^ reference_compare_value[i];
      assign vs_prev = port_bits[i] ^ previous_level[i];
      assign pin_cond[i] = armed && (compare_mode_select[i] ? vs_ref : vs_prev);
      // Flag holds until a clearing read; a live condition sets it again
      assign next_flags[i] = pin_cond[i] || (interrupt_flags[i] && !rd_clear);
    end
  endgenerate

  assign any_cond = |pin_cond;

  // A new interrupt only when none pending or it clears this cycle
  assign new_event = any_cond && (!irq_pending || rd_clear);

  // ==========================================================
  // Pending state; a set wins over a clear in the same cycle
  always @* begin
    next_state = irq_state;
    case (irq_state)
      ST_IDLE: begin
        if (any_cond) begin
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        // Only a clearing read leaves, and only with no live condition
        if (rd_clear && !any_cond) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign irq_pending = (irq_state == ST_HELD);
  assign next_pending = (next_state == ST_HELD);

  // ==========================================================
  // Interrupt pin drive
  always @* begin
    next_int_out = 1'b0;
    next_int_oe = 1'b1;
    case ({open_drain_select, irq_polarity})
      PIN_PUSH_LOW: begin
        next_int_out = !next_pending;
      end
      PIN_PUSH_HIGH: begin
        next_int_out = next_pending;
      end
      default: begin
        // Open drain pulls low while active, polarity ignored
        next_int_out = 1'b0;
        next_int_oe = next_pending;
      end
    endcase
  end

  // ==========================================================
  // Read mux
  always @* begin
    next_rdata = `IOPC_READ_ZERO;
    case (I_REG_ADDR)
      `IOPC_ADDR_CHG_EN: begin
        next_rdata = chg_irq_enable;
      end
      `IOPC_ADDR_REF_VAL: begin
        next_rdata = reference_compare_value;
      end
      `IOPC_ADDR_MODE_SEL: begin
        next_rdata = compare_mode_select;
      end
      `IOPC_ADDR_CONFIG: begin
        next_rdata = expander_config[WIDTH-1:0];
      end
      `IOPC_ADDR_PULLUP: begin
        next_rdata = pullup_enable;
      end
      `IOPC_ADDR_FLAGS: begin
        next_rdata = interrupt_flags;
      end
      `IOPC_ADDR_CAPTURE: begin
        next_rdata = captured_port_value;
      end
      `IOPC_ADDR_PORT: begin
        next_rdata = port_bits;
      end
      `IOPC_ADDR_LATCH: begin
        next_rdata = O_LATCH;
      end
      default: begin
        next_rdata = `IOPC_READ_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Configuration registers
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      chg_irq_enable <= `IOPC_RST_CHG_EN;
      reference_compare_value <= `IOPC_RST_REF_VAL;
      compare_mode_select <= `IOPC_RST_MODE_SEL;
      expander_config <= `IOPC_RST_CONFIG;
      pullup_enable <= `IOPC_RST_PULLUP;
      O_LATCH <= `IOPC_RST_LATCH;
    end else if (I_CE) begin
      if (wr_chg_en) begin
        chg_irq_enable <= I_REG_WDATA;
      end
      if (wr_ref_val) begin
        reference_compare_value <= I_REG_WDATA;
      end
      if (wr_mode_sel) begin
        compare_mode_select <= I_REG_WDATA;
      end
      if (wr_config) begin
        expander_config <= I_REG_WDATA & `IOPC_CFG_MASK;
      end
      if (wr_pullup) begin
        pullup_enable <= I_REG_WDATA;
      end
      if (wr_latch) begin
        O_LATCH <= I_REG_WDATA;
      end
    end
  end

  // ==========================================================
  // Interrupt state; flags and capture have no write path
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      interrupt_flags <= `IOPC_RST_FLAGS;
      irq_state <= ST_IDLE;
    end else if (I_CE) begin
      interrupt_flags <= next_flags;
      irq_state <= next_state;
    end
  end

  // ==========================================================
  // Capture on the activating event only
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      captured_port_value <= `IOPC_RST_CAPTURE;
      previous_level <= {WIDTH{1'b0}};
    end else if (I_CE) begin
      if (new_event) begin
        captured_port_value <= port_bits;
      end
      // Previous level follows the pin, so a change flags once
      previous_level <= port_bits;
    end
  end

  // ==========================================================
  // Read answer: valid pulses one cycle, data holds until the next read
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= `IOPC_READ_ZERO;
      O_REG_RVALID <= 1'b0;
    end else if (I_CE) begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        O_REG_RDATA <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Pin drive: reset leaves the interrupt pin push-pull and inactive
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_PULLUP_EN <= {WIDTH{1'b0}};
      O_INT_OUT <= 1'b1;
      O_INT_OE <= 1'b1;
    end else if (I_CE) begin
      O_PULLUP_EN <= pullup_enable & I_PIN_IS_INPUT;
      O_INT_OUT <= next_int_out;
      O_INT_OE <= next_int_oe;
    end
  end

endmodule // iopc_top

`default_nettype wire

/* hw/iopc_consts.vh */
// Register offsets, field positions, reset values and timing counts of the port block
`ifndef IOPC_CONSTS_VH
`define IOPC_CONSTS_VH

// ==========================================================
// Register offsets
`define IOPC_ADDR_CHG_EN 8'h02
`define IOPC_ADDR_REF_VAL 8'h03
`define IOPC_ADDR_MODE_SEL 8'h04
`define IOPC_ADDR_CONFIG 8'h05
`define IOPC_ADDR_PULLUP 8'h06
`define IOPC_ADDR_FLAGS 8'h07
`define IOPC_ADDR_CAPTURE 8'h08
`define IOPC_ADDR_PORT 8'h09
`define IOPC_ADDR_LATCH 8'h0A

// ==========================================================
// Configuration fields
`define IOPC_CFG_OD_BIT 2
`define IOPC_CFG_POL_BIT 1
`define IOPC_CFG_MASK 8'h3E

// ==========================================================
// Reset values
`define IOPC_RST_CHG_EN 8'h00
`define IOPC_RST_REF_VAL 8'h00
`define IOPC_RST_MODE_SEL 8'h00
`define IOPC_RST_CONFIG 8'h00
`define IOPC_RST_PULLUP 8'h00
`define IOPC_RST_FLAGS 8'h00
`define IOPC_RST_CAPTURE 8'h00
`define IOPC_RST_LATCH 8'h00
`define IOPC_READ_ZERO 8'h00

// ==========================================================
// Timing counts
`define IOPC_SYNC_STAGES 2

`endif

/* hw/iopc_sync.v */
// Multi-stage synchroniser for the port pin levels
`timescale 1ns/1ps
`default_nettype none

module iopc_sync #(
  parameter WIDTH = 8,
  parameter STAGES = 2
) (
  // Clock, reset and enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Data
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  // ==========================================================
  // Stage chain: stage 0 is read only by stage 1
  genvar s;
  generate
    for (s = 0; s < STAGES; s = s + 1) begin : g_stage
      reg [WIDTH-1:0] flop;
      if (s == 0) begin : g_first
        always @(posedge clk) begin
          if (!rst_n) begin
            flop <= {WIDTH{1'b0}};
          end else if (ce) begin
            flop <= d;
          end
        end
      end else begin : g_next
        always @(posedge clk) begin
          if (!rst_n) begin
            flop <= {WIDTH{1'b0}};
          end else if (ce) begin
            flop <= g_stage[s-1].flop;
          end
        end
      end
    end
  endgenerate

  assign q = g_stage[STAGES-1].flop;

endmodule // iopc_sync

`default_nettype wire

/* tb/iopc_chk_assertions.sv */
// Concurrent checks on the port block's register port and pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module iopc_chk #(
  parameter WIDTH = 8
) (
  // Clock, reset and enable
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [WIDTH-1:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  input wire logic [WIDTH-1:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  // Pins
  input wire logic [WIDTH-1:0] I_PIN_LEVEL,
  input wire logic [WIDTH-1:0] I_PIN_IS_INPUT,
  input wire logic [WIDTH-1:0] O_LATCH,
  input wire logic [WIDTH-1:0] O_PULLUP_EN,
  input wire logic O_INT_OUT,
  input wire logic O_INT_OE
);
  wire lat_wr = I_CE && I_REG_WR && (I_REG_ADDR == 8'h09 || I_REG_ADDR == 8'h0A);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  read_valid_a: assert property (I_CE && I_REG_RD |=> O_REG_RVALID)
    else $error("read strobe gave no valid pulse");
  valid_quiet_a: assert property (I_CE && !I_REG_RD |=> !O_REG_RVALID)
    else $error("valid pulse without read");
  rdata_hold_a: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without read");
  pullup_mask_a: assert property ((O_PULLUP_EN & ~$past(I_PIN_IS_INPUT)) == 8'h00)
    else $error("pull-up on an output pin");
  open_drain_a: assert property (!O_INT_OE |-> !O_INT_OUT)
    else $error("released interrupt pin not low");
  latch_load_a: assert property (lat_wr |=> O_LATCH == $past(I_REG_WDATA))
    else $error("latch not loaded by write");
  latch_hold_a: assert property (!lat_wr |=> $stable(O_LATCH))
    else $error("latch moved without write");
  unmapped_zero_a: assert property (I_CE && I_REG_RD && I_REG_ADDR > 8'h0A |=>
    O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  ce_freeze_a: assert property (!I_CE |=>
    $stable({O_LATCH, O_PULLUP_EN, O_INT_OUT, O_INT_OE, O_REG_RVALID}))
    else $error("outputs moved with clock enable low");
endmodule // iopc_chk
bind iopc_top iopc_chk #(.WIDTH(WIDTH)) iopc_chk_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_CE(I_CE), .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA),
  .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
  .I_PIN_LEVEL(I_PIN_LEVEL), .I_PIN_IS_INPUT(I_PIN_IS_INPUT), .O_LATCH(O_LATCH),
  .O_PULLUP_EN(O_PULLUP_EN), .O_INT_OUT(O_INT_OUT), .O_INT_OE(O_INT_OE));
`default_nettype wire

/* tb/iopc_host.sv */
// Host controller model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host
module iopc_host (
  // Clock and read answer
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Register strobes
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // Released data is inverted so stale values never look valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask
endmodule // iopc_host
`default_nettype wire

/* tb/io_port_change_interrupt_bench.sv */
// Self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module io_port_change_interrupt_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] pins = 8'h00;
  logic [7:0] dir = 8'h00;
  logic [7:0] v;
  wire [7:0] addr, wdata, rdata, latch, pu;
  wire wr, rd, rvalid, int_out, int_oe;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 16613;
  int regs [0:15];
  int d;
  always #4 clk = ~clk;
  iopc_top iopc_top_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .I_PIN_LEVEL(pins), .I_PIN_IS_INPUT(dir), .O_LATCH(latch),
    .O_PULLUP_EN(pu), .O_INT_OUT(int_out), .O_INT_OE(int_oe));
  iopc_host iopc_host_inst (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr),
    .wr(wr), .wdata(wdata), .rd(rd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input int a, input int e);
    iopc_host_inst.read(a[7:0], v);
    chk(v, e[7:0]);
  endtask
  task automatic wreg(input int a, input int e);
    iopc_host_inst.write(a[7:0], e[7:0]);
    regs[a] = (a == 5) ? (e & 'h3E) : e;
  endtask
  // Expected {oe, out} of the interrupt pin for a pending state
  task automatic ichk(input bit p);
    chk({6'h00, int_oe, int_out}, regs[5][2] ? {6'h00, p, 1'b0} :
      {6'h00, 1'b1, regs[5][1] ? p : ~p});
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    for (int a = 0; a < 16; a++) regs[a] = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 2; a <= 10; a++) rchk(a, 0);
    ichk(0);
    // All pins outputs: random interrupt setup must stay silent
    for (int a = 2; a <= 10; a++) begin
      d = $random(seed) & 'hFF;
      iopc_host_inst.write(a[7:0], d[7:0]);
      if (a == 9) regs[10] = d;
      else if (a < 7 || a == 10) regs[a] = (a == 5) ? (d & 'h3E) : d;
    end
    for (int a = 2; a <= 11; a++) rchk(a, a == 11 ? 0 : a == 9 ? pins : regs[a]);
    chk(latch, regs[10][7:0]);
    ichk(0);
    d = $random(seed);
    dir = d[7:0];
    repeat (2) @(negedge clk);
    chk(pu, regs[6][7:0] & dir);
    // Previous-value mode, pin 2 an output
    dir = 8'hFB;
    wreg(2, 'h07);
    wreg(4, 'h00);
    wreg(5, 'h00);
    settle;
    iopc_host_inst.read(8'h08, v);
    rchk(7, 0);
    pins[2] = 1'b1;
    settle;
    ichk(0);
    pins[0] = 1'b1;
    settle;
    ichk(1);
    pins[1] = 1'b1;
    settle;
    rchk(7, 'h03);
    wreg(8, 0);
    iopc_host_inst.write(8'h09, 8'h5A);
    regs[10] = 'h5A;
    ichk(1);
    rchk(8, 'h05);
    ichk(0);
    rchk(7, 0);
    pins[0] = 1'b0;
    settle;
    ichk(1);
    rchk(9, 'h06);
    ichk(0);
    rchk(10, 'h5A);
    // Reference mode on the upper pins, all pin drive options
    wreg(3, 'h00);
    wreg(4, 'hF0);
    wreg(2, 'hF0);
    pins[4] = 1'b1;
    settle;
    for (int c = 0; c <= 4; c += 2) begin
      wreg(5, c);
      @(negedge clk);
      ichk(1);
    end
    rchk(9, 'h16);
    ichk(1);
    rchk(7, 'h10);
    pins[4] = 1'b0;
    settle;
    rchk(8, 'h16);
    ichk(0);
    // Clock enable low: a write is dropped and a pin change waits
    ce = 1'b0;
    iopc_host_inst.write(8'h0A, 8'hC3);
    pins[5] = 1'b1;
    settle;
    chk(latch, regs[10][7:0]);
    ichk(0);
    ce = 1'b1;
    settle;
    ichk(1);
    rchk(7, 'h20);
    // Reset in mid-run returns every register to its reset value
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 2; a <= 10; a++) regs[a] = 0;
    chk(latch, 8'h00);
    ichk(0);
    for (int a = 2; a <= 10; a++) rchk(a, a == 9 ? 'h26 : 0);
    give_verdict;
  end
endmodule // io_port_change_interrupt_bench
`default_nettype wire
